/* shared/scc_pkg.sv */
package scc_pkg;
  localparam int DIV1_N = 256;
  localparam int DIV2_N = 128;
  localparam logic [7:0] DIV1_LAST = 8'(DIV1_N - 1);
  localparam logic [6:0] DIV2_LAST = 7'(DIV2_N - 1);
  // Bus address value is arbitrary
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h5a;
  localparam logic [4:0] SYNC_RST = 5'h06;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [2:0] FRAME_BYTES = 3'h6;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_SEC = 3'h1;
  localparam logic [2:0] IDX_MIN = 3'h2;
  localparam logic [2:0] IDX_HR = 3'h3;
  localparam logic [2:0] IDX_DAY = 3'h4;
  localparam logic [2:0] IDX_MON = 3'h5;
  localparam int MODE_BIT = 2;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HR_MAX = 5'h17;
  localparam logic [5:0] SYNC_HALF = 6'h1e;
  localparam logic [3:0] MON_MAX = 4'hc;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [3:0] MON_MAR = 4'h3;
  localparam logic [4:0] DAYS_FEB = 5'h1c;
  localparam logic [4:0] DAYS_SHORT = 5'h1e;
  localparam logic [4:0] DAYS_LONG = 5'h1f;
  localparam logic [2:0] WDAY_MAX = 3'h7;
  localparam logic [4:0] RST_DAY = 5'h01;
  localparam logic [3:0] RST_MON = 4'h1;
  localparam logic [2:0] RST_WDAY = 3'h1;
  typedef enum logic [2:0] {
    SCC_IDLE = 3'b000,
    SCC_ADDR = 3'b001,
    SCC_SACK = 3'b011,
    SCC_DATA = 3'b010,
    SCC_MACK = 3'b110
  } scc_state_t;
endpackage

/* rtl/scc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - Crystal divided by 256 then 128
// R2 - Master reads and overwrites time counters
// R3 - Write loads minutes up, clears seconds
// R4 - First byte bit two selects weekday mode
// R5 - Weekday counter runs one through seven
// R6 - Day rolls at 28, 30, 31 per month
// R7 - February 29 only by write, then March
// R8 - Transfer opens with start then address
// R9 - Own address starts transfer; LSB direction
// R10 - Master alone clocks SCL
// R11 - Master never aborts a started transfer
// R12 - Serial clock from DC to 100kHz
// R13 - One carry held during transfer, applied after
// R14 - Master keeps transfers under one second
// R15 - Address-only write synchronises seconds and divider
// R16 - Sync from 30..59 also bumps minutes
// R17 - Power loss blanks read data
// R18 - First full write re-enables real data
// R19 - 128Hz tap on divider tap pin
// R20 - 1Hz square on seconds pin
// R21 - Test sources override tap and seconds
// R22 - Ninth clock acknowledges; stop ends transfer
// R23 - Fixed byte order and encoding per mode
module scc_top #(
  parameter logic [6:0] DEV_ADDR = scc_pkg::DEV_ADDR_DFLT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic xtal_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic test_en,
  input wire logic tap_test_in,
  input wire logic sec_test_in,
  output logic divider_tap_output,
  output logic sec_pulse_out
);
  logic [4:0] s1_r, s2_r, s3_r, rise, fall;
  logic scl_hi, start_evt, stop_evt;
  logic [7:0] cnt1_r, cnt1_nxt;
  logic [6:0] cnt2_r, cnt2_nxt;
  logic tick128, tick1, clr_div;
  scc_pkg::scc_state_t st_r, st_nxt;
  logic [3:0] bc_r, bc_nxt;
  logic [7:0] sh_r, sh_nxt, rd_byte;
  logic [2:0] idx_r, idx_nxt;
  logic rw_r, rw_nxt, busy_r, busy_nxt, oe_r, oe_nxt, mack_r, mack_nxt, push, end_evt;
  localparam int FIFO_DEPTH_L = scc_pkg::FIFO_DEPTH;
  logic [7:0] mem_r [FIFO_DEPTH_L];
  logic [7:0] mem_nxt [FIFO_DEPTH_L];
  logic wp_r, wp_nxt, rp_r, rp_nxt, in_ready, out_valid, pop;
  logic [1:0] fc_r, fc_nxt;
  logic [5:0] sec_r, sec_nxt, min_r, min_nxt;
  logic [4:0] hr_r, hr_nxt, day_r, day_nxt, mdays;
  logic [3:0] mon_r, mon_nxt;
  logic [2:0] wday_r, wday_nxt, scnt_r, scnt_nxt;
  logic mode_r, mode_nxt, pf_r, pf_nxt, pend_r, pend_nxt, endp_r, endp_nxt;
  logic [7:0] stg_r [6];
  logic [7:0] stg_nxt [6];
  logic adv, done, sync_now, commit, cm, ch, cd;
  logic te1_r, te2_r;

  // Two flops on every pin; third stage feeds edge detection and the SCL-high check [R12]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= scc_pkg::SYNC_RST;
      s2_r <= scc_pkg::SYNC_RST;
      s3_r <= scc_pkg::SYNC_RST;
      te1_r <= 1'b0;
      te2_r <= 1'b0;
    end else begin
      s1_r <= {sec_test_in, tap_test_in, sda_in, scl_in, xtal_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Test enable is a pin too, so it is synchronised like the rest
      te1_r <= test_en;
      te2_r <= te1_r;
    end
  end
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
  assign scl_hi = s2_r[1] & s3_r[1];
  assign start_evt = scl_hi & fall[2]; // [R8]
  assign stop_evt = scl_hi & rise[2]; // [R22]

  always_comb begin
    cnt1_nxt = cnt1_r;
    cnt2_nxt = cnt2_r;
    tick128 = 1'b0;
    tick1 = 1'b0;
    if (rise[0]) begin
      cnt1_nxt = cnt1_r + 8'h01; // [R1]
      tick128 = (cnt1_r == scc_pkg::DIV1_LAST);
    end
    // Test pins replace the stage outputs to shorten counter tests
    if (te2_r) tick128 = rise[3]; // [R21]
    if (tick128) begin
      cnt2_nxt = cnt2_r + 7'h01; // [R1]
      tick1 = (cnt2_r == scc_pkg::DIV2_LAST);
    end
    if (te2_r) tick1 = rise[4]; // [R21]
    if (clr_div) cnt2_nxt = 7'h00; // [R3] [R15]
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt1_r <= 8'h00;
      cnt2_r <= 7'h00;
    end else begin
      cnt1_r <= cnt1_nxt;
      cnt2_r <= cnt2_nxt;
    end
  end
  assign divider_tap_output = cnt1_r[7]; // [R19]
  assign sec_pulse_out = cnt2_r[6]; // [R20]

  // Serial slave; SCL is only ever sampled, never driven [R10]
  always_comb begin
    st_nxt = st_r;
    bc_nxt = bc_r;
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    rw_nxt = rw_r;
    busy_nxt = busy_r;
    oe_nxt = oe_r;
    mack_nxt = mack_r;
    push = 1'b0;
    end_evt = 1'b0;
    if (start_evt || stop_evt) begin
      end_evt = busy_r; // [R13]
      busy_nxt = 1'b0;
      oe_nxt = 1'b0;
      bc_nxt = 4'h0;
      st_nxt = start_evt ? scc_pkg::SCC_ADDR : scc_pkg::SCC_IDLE; // [R8] [R22]
    end else begin
      unique case (st_r)
        scc_pkg::SCC_IDLE: begin
          st_nxt = scc_pkg::SCC_IDLE;
        end
        scc_pkg::SCC_ADDR: begin
          if (rise[1]) begin
            sh_nxt = {sh_r[6:0], s2_r[2]};
            bc_nxt = bc_r + 4'h1;
          end
          if (fall[1] && bc_r == scc_pkg::BITS_BYTE) begin
            if (sh_r[7:1] == DEV_ADDR) begin
              st_nxt = scc_pkg::SCC_SACK; // [R9]
              oe_nxt = 1'b1; // [R22]
              rw_nxt = sh_r[0]; // [R9]
              busy_nxt = 1'b1;
              idx_nxt = scc_pkg::IDX_CTRL;
            end else begin
              st_nxt = scc_pkg::SCC_IDLE;
            end
          end
        end
        scc_pkg::SCC_SACK: begin
          if (fall[1]) begin
            st_nxt = scc_pkg::SCC_DATA;
            bc_nxt = 4'h0;
            oe_nxt = 1'b0;
            if (rw_r) begin
              sh_nxt = rd_byte; // [R2]
              oe_nxt = ~rd_byte[7];
              idx_nxt = idx_r + 3'h1;
              bc_nxt = 4'h1;
            end
          end
        end
        scc_pkg::SCC_DATA: begin
          if (rw_r) begin
            if (fall[1]) begin
              if (bc_r == scc_pkg::BITS_BYTE) begin
                oe_nxt = 1'b0;
                mack_nxt = 1'b0;
                st_nxt = scc_pkg::SCC_MACK;
              end else begin
                sh_nxt = {sh_r[6:0], 1'b0};
                oe_nxt = ~sh_r[6];
                bc_nxt = bc_r + 4'h1;
              end
            end
          end else begin
            if (rise[1]) begin
              sh_nxt = {sh_r[6:0], s2_r[2]};
              bc_nxt = bc_r + 4'h1;
            end
            if (fall[1] && bc_r == scc_pkg::BITS_BYTE) begin
              // A full buffer refuses the byte with a missing acknowledge
              push = in_ready;
              oe_nxt = in_ready; // [R22]
              st_nxt = in_ready ? scc_pkg::SCC_SACK : scc_pkg::SCC_IDLE;
            end
          end
        end
        scc_pkg::SCC_MACK: begin
          if (rise[1]) mack_nxt = ~s2_r[2]; // [R22]
          if (fall[1]) begin
            if (mack_r) begin
              sh_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              idx_nxt = idx_r + 3'h1;
              bc_nxt = 4'h1;
              st_nxt = scc_pkg::SCC_DATA;
            end else begin
              st_nxt = scc_pkg::SCC_IDLE;
            end
          end
        end
        default: st_nxt = scc_pkg::SCC_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= scc_pkg::SCC_IDLE;
      bc_r <= 4'h0;
      sh_r <= 8'h00;
      idx_r <= 3'h0;
      rw_r <= 1'b0;
      busy_r <= 1'b0;
      oe_r <= 1'b0;
      mack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bc_r <= bc_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      rw_r <= rw_nxt;
      busy_r <= busy_nxt;
      oe_r <= oe_nxt;
      mack_r <= mack_nxt;
    end
  end
  assign sda_oe = oe_r;
  assign sda_out = 1'b0;

  // Read map; counters are frozen while busy so the frame is coherent
  always_comb begin
    rd_byte = 8'h00;
    if (pf_r) begin // [R17]
      unique case (idx_r) // [R23]
        scc_pkg::IDX_CTRL: rd_byte[scc_pkg::MODE_BIT] = mode_r;
        scc_pkg::IDX_SEC: rd_byte = {2'h0, sec_r};
        scc_pkg::IDX_MIN: rd_byte = {2'h0, min_r};
        scc_pkg::IDX_HR: rd_byte = {3'h0, hr_r};
        scc_pkg::IDX_DAY: rd_byte = mode_r ? {5'h00, wday_r} : {3'h0, day_r};
        scc_pkg::IDX_MON: rd_byte = {4'h0, mon_r};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Two-entry buffer between receiver and staging
  assign in_ready = (fc_r != scc_pkg::FIFO_FULL);
  assign out_valid = (fc_r != 2'h0);
  assign pop = out_valid & ~adv;
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    fc_nxt = fc_r;
    if (push) begin
      mem_nxt[wp_r] = sh_r;
      wp_nxt = ~wp_r;
    end
    if (pop) rp_nxt = ~rp_r;
    fc_nxt = fc_r + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_r <= '{default: 8'h00};
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      fc_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      fc_r <= fc_nxt;
    end
  end

  always_comb begin
    unique case (mon_r) // [R6]
      scc_pkg::MON_FEB: mdays = scc_pkg::DAYS_FEB;
      4'h4, 4'h6, 4'h9, 4'hb: mdays = scc_pkg::DAYS_SHORT;
      default: mdays = scc_pkg::DAYS_LONG;
    endcase
  end
  assign adv = (tick1 | pend_r) & ~busy_r & ~endp_r;
  assign done = endp_r & ~out_valid;
  assign sync_now = done & ~rw_r & (scnt_r == 3'h0); // [R15]
  assign commit = done & ~rw_r & (scnt_r == scc_pkg::FRAME_BYTES); // [R3]
  assign clr_div = sync_now | commit;
  always_comb begin
    sec_nxt = sec_r;
    min_nxt = min_r;
    hr_nxt = hr_r;
    day_nxt = day_r;
    mon_nxt = mon_r;
    wday_nxt = wday_r;
    mode_nxt = mode_r;
    pf_nxt = pf_r;
    pend_nxt = pend_r;
    endp_nxt = endp_r | end_evt;
    scnt_nxt = scnt_r;
    stg_nxt = stg_r;
    cm = 1'b0;
    if ((busy_r | endp_r) & tick1) pend_nxt = 1'b1; // [R13]
    if (adv) pend_nxt = 1'b0; // [R13]
    if (pop && scnt_r != scc_pkg::FRAME_BYTES) begin
      stg_nxt[scnt_r] = mem_r[rp_r];
      scnt_nxt = scnt_r + 3'h1;
    end
    if (done) begin
      // A new end in the same cycle must not be lost
      endp_nxt = end_evt;
      scnt_nxt = 3'h0;
    end
    if (adv) begin
      cm = (sec_r == scc_pkg::SEC_MAX);
      sec_nxt = cm ? 6'h00 : sec_r + 6'h01;
    end
    if (sync_now) begin
      sec_nxt = 6'h00; // [R15]
      cm = (sec_r >= scc_pkg::SYNC_HALF); // [R16]
      pend_nxt = 1'b0;
    end
    ch = cm && (min_r == scc_pkg::MIN_MAX);
    cd = ch && (hr_r == scc_pkg::HR_MAX);
    if (cm) min_nxt = ch ? 6'h00 : min_r + 6'h01;
    if (ch) hr_nxt = cd ? 5'h00 : hr_r + 5'h01;
    if (cd && mode_r) wday_nxt = (wday_r >= scc_pkg::WDAY_MAX) ? scc_pkg::RST_WDAY : wday_r + 3'h1; // [R5]
    if (cd && !mode_r) begin
      // A written 29 in February is also past the limit, so it rolls to March
      if (day_r >= mdays) begin // [R6] [R7]
        day_nxt = scc_pkg::RST_DAY;
        mon_nxt = (mon_r >= scc_pkg::MON_MAX) ? scc_pkg::RST_MON : mon_r + 4'h1;
      end else begin
        day_nxt = day_r + 5'h01;
      end
    end
    if (commit) begin
      sec_nxt = 6'h00; // [R3]
      min_nxt = stg_r[scc_pkg::IDX_MIN][5:0]; // [R2]
      hr_nxt = stg_r[scc_pkg::IDX_HR][4:0];
      day_nxt = stg_r[scc_pkg::IDX_DAY][4:0]; // [R7]
      mon_nxt = stg_r[scc_pkg::IDX_MON][3:0];
      wday_nxt = stg_r[scc_pkg::IDX_DAY][2:0];
      if (wday_nxt == 3'h0) wday_nxt = scc_pkg::RST_WDAY; // [R5]
      mode_nxt = stg_r[scc_pkg::IDX_CTRL][scc_pkg::MODE_BIT]; // [R4]
      pf_nxt = 1'b1; // [R18]
      pend_nxt = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sec_r <= 6'h00;
      min_r <= 6'h00;
      hr_r <= 5'h00;
      day_r <= scc_pkg::RST_DAY;
      mon_r <= scc_pkg::RST_MON;
      wday_r <= scc_pkg::RST_WDAY;
      mode_r <= 1'b0;
      pf_r <= 1'b0; // [R17]
      pend_r <= 1'b0;
      endp_r <= 1'b0;
      scnt_r <= 3'h0;
      stg_r <= '{default: 8'h00};
    end else begin
      sec_r <= sec_nxt;
      min_r <= min_nxt;
      hr_r <= hr_nxt;
      day_r <= day_nxt;
      mon_r <= mon_nxt;
      wday_r <= wday_nxt;
      mode_r <= mode_nxt;
      pf_r <= pf_nxt;
      pend_r <= pend_nxt;
      endp_r <= endp_nxt;
      scnt_r <= scnt_nxt;
      stg_r <= stg_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_one_hz_chain: assert property (tick128 && !te2_r && !clr_div // [R1]
    |=> cnt1_r == 8'h00 && cnt2_r == $past(cnt2_r) + 7'h01)
    else $error("128Hz stage did not feed the second stage");
  chk_sec_step: assert property (adv |=> sec_r == ($past(sec_r) == scc_pkg::SEC_MAX ? 6'h00 : $past(sec_r) + 6'h01)) // [R1]
    else $error("seconds did not step");
  chk_write_clr: assert property (commit |=> sec_r == 6'h00 && cnt2_r == 7'h00 && pf_r) // [R3]
    else $error("write did not clear seconds");
  chk_mode_sel: assert property (commit |=> mode_r == $past(stg_r[0][2])) // [R4]
    else $error("mode bit not taken");
  chk_wday_range: assert property (wday_r >= 3'h1 && wday_r <= scc_pkg::WDAY_MAX) // [R5]
    else $error("weekday out of range");
  chk_feb_roll: assert property (cd && !mode_r && mon_r == scc_pkg::MON_FEB && day_r >= scc_pkg::DAYS_FEB // [R7]
    && !commit |=> day_r == scc_pkg::RST_DAY && mon_r == scc_pkg::MON_MAR)
    else $error("February did not roll to March");
  chk_addr_miss: assert property (st_r == scc_pkg::SCC_ADDR && fall[1] && bc_r == scc_pkg::BITS_BYTE // [R9]
    && sh_r[7:1] != DEV_ADDR |=> st_r == scc_pkg::SCC_IDLE && !sda_oe)
    else $error("foreign address answered");
  chk_carry_hold: assert property (tick1 && busy_r |=> pend_r [*1] ##0 !adv) // [R13]
    else $error("carry lost in transfer");
  chk_sync_min: assert property (sync_now && sec_r >= scc_pkg::SYNC_HALF && min_r != scc_pkg::MIN_MAX // [R16]
    |=> sec_r == 6'h00 && min_r == $past(min_r) + 6'h01)
    else $error("sync carry to minutes missing");
  // Blanked data reads as zero, so the first bit pulls the wire low
  chk_pf_blank: assert property (!pf_r && st_r == scc_pkg::SCC_SACK && rw_r && fall[1] |=> sda_oe) // [R17]
    else $error("blanked read sent a one");
  cov_commit: cover property (commit);
  cov_sync: cover property (sync_now);
  cov_read: cover property (st_r == scc_pkg::SCC_MACK && rw_r && pf_r);
  cov_pend: cover property (pend_r && adv);
endmodule
`default_nettype wire

/* sim/scc_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scc_master_model (
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic low_r;
  initial begin
    scl = 1'b1;
    low_r = 1'b0;
  end
  // Pull-up wire, low while either party pulls it
  assign sda = !(sda_oe | low_r);
  // Only the master moves the clock, at least 4 sys_clk per level
  task automatic step(input logic s, input logic l, input int n);
    @(posedge sys_clk);
    scl <= s;
    low_r <= l;
    repeat (n - 1) @(posedge sys_clk);
  endtask
  // Data moves only while the clock is low, so no false start or stop
  task automatic bit_slot(input logic b, output logic s);
    step(1'b0, low_r, 2);
    step(1'b0, !b, 2);
    step(1'b1, !b, 4);
    s = sda;
  endtask
  task automatic start();
    step(1'b1, 1'b0, 4);
    step(1'b1, 1'b1, 4);
  endtask
  task automatic stop();
    step(1'b0, low_r, 2);
    step(1'b0, 1'b1, 2);
    step(1'b1, 1'b1, 4);
    step(1'b1, 1'b0, 4);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, ack);
  endtask
  // Acks every byte but the last and never aborts a frame
  task automatic rd_byte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(last, s);
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic xtal_in = 1'b0;
  logic test_en = 1'b0;
  logic tap_test_in = 1'b0;
  logic sec_test_in = 1'b0;
  logic scl, sda, sda_out, sda_oe, tap, sec_pulse;
  logic [1:0] xdiv = 2'h0;
  int mismatches = 0;
  int n_tests = 0;
  int xcnt = 0;
  always #12.5 sys_clk = ~sys_clk;
  // Fast timebase keeps the first stage measurable in a short run
  always @(posedge sys_clk) begin
    xdiv <= xdiv + 2'h1;
    if (xdiv == 2'h3) xtal_in <= ~xtal_in;
  end
  always @(posedge xtal_in) xcnt++;
  scc_top uut (.sys_clk(sys_clk), .rst(rst), .xtal_in(xtal_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .test_en(test_en), .tap_test_in(tap_test_in),
    .sec_test_in(sec_test_in), .divider_tap_output(tap), .sec_pulse_out(sec_pulse));
  scc_master_model m (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Mismatches %0d in %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_tap_rise();
    logic p;
    p = tap;
    for (int i = 0; i < 5000; i++) begin
      @(posedge sys_clk);
      if (p === 1'b0 && tap === 1'b1) return;
      p = tap;
    end
    mismatches++;
    $display("ERROR %0t: no tap edge", $time);
    complete_run();
  endtask
  task automatic send_addr(input logic [6:0] a, input logic rd, input logic exp_ack);
    logic ack;
    m.start();
    m.wr_byte({a, rd}, ack);
    check(48'(ack), 48'(exp_ack));
  endtask
  // Seconds byte is sent non-zero on purpose: it must be ignored
  task automatic write_frame(input logic [7:0] c, mi, h, d, mo);
    logic [47:0] f;
    logic ack;
    f = {c, 8'h22, mi, h, d, mo};
    send_addr(scc_pkg::DEV_ADDR_DFLT, 1'b0, 1'b0);
    for (int i = 5; i >= 0; i--) begin
      m.wr_byte(f[i*8 +: 8], ack);
      check(48'(ack), 48'h0);
    end
    m.stop();
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic read_frame(output logic [47:0] f);
    logic [7:0] b;
    send_addr(scc_pkg::DEV_ADDR_DFLT, 1'b1, 1'b0);
    for (int i = 5; i >= 0; i--) begin
      m.rd_byte(b, i == 0);
      f[i*8 +: 8] = b;
    end
    m.stop();
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic sync_frame();
    send_addr(scc_pkg::DEV_ADDR_DFLT, 1'b0, 1'b0);
    m.stop();
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      sec_test_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sec_test_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task automatic s_taps();
    int c0;
    wait_tap_rise();
    c0 = xcnt;
    wait_tap_rise();
    check(48'(xcnt - c0), 48'(scc_pkg::DIV1_N));
  endtask
  // A sync alone must not lift the blanking
  task automatic s_blank();
    logic [47:0] f;
    read_frame(f);
    check(f, 48'h0);
    sync_frame();
    read_frame(f);
    check(f, 48'h0);
  endtask
  task automatic s_foreign();
    send_addr(scc_pkg::DEV_ADDR_DFLT ^ 7'h01, 1'b0, 1'b1);
    check(48'(sda_out), 48'h0);
    m.stop();
  endtask
  // A sync clears the second stage; 64 test steps on the tap pin flip the seconds pin
  task automatic s_pulse();
    sync_frame();
    check(48'(sec_pulse), 48'h0);
    repeat (64) begin
      @(posedge sys_clk);
      tap_test_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      tap_test_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    check(48'(sec_pulse), 48'h1);
  endtask
  task automatic s_weekday();
    logic [47:0] f;
    write_frame(8'h04, 8'h3b, 8'h17, 8'h07, 8'h01);
    tick(60);
    read_frame(f);
    check(48'(f[39:8]), 48'h0000_0001);
  endtask
  // Rows: day, month, next day, next month at the midnight carry
  task automatic s_roll();
    logic [47:0] f;
    logic [31:0] rows [6];
    rows = '{32'h1f01_0102, 32'h1e01_1f01, 32'h1c02_0103, 32'h1d02_0103, 32'h1e04_0105, 32'h1f0c_0101};
    foreach (rows[k]) begin
      write_frame(8'h00, 8'h3b, 8'h17, rows[k][31:24], rows[k][23:16]);
      read_frame(f);
      check(48'(f[39:0]), 48'({8'h00, 8'h3b, 8'h17, rows[k][31:16]}));
      tick(60);
      read_frame(f);
      check(48'(f[39:0]), 48'({24'h0, rows[k][15:0]}));
    end
  endtask
  // 35 s is past the half-minute, 29 s is just short of it
  task automatic s_sync();
    logic [47:0] f;
    write_frame(8'h00, 8'h14, 8'h0a, 8'h01, 8'h01);
    tick(35);
    sync_frame();
    read_frame(f);
    check(48'(f[39:16]), 48'h00_150a);
    tick(29);
    sync_frame();
    read_frame(f);
    check(48'(f[39:16]), 48'h00_150a);
  endtask
  task automatic s_carry();
    logic [47:0] f;
    write_frame(8'h00, 8'h14, 8'h0a, 8'h01, 8'h01);
    fork
      read_frame(f);
      begin
        repeat (150) @(posedge sys_clk);
        tick(1);
      end
    join
    read_frame(f);
    check(48'(f[39:24]), 48'h0114);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    s_taps();
    s_blank();
    test_en <= 1'b1;
    s_foreign();
    s_weekday();
    s_roll();
    s_sync();
    s_pulse();
    s_carry();
    complete_run();
  end
endmodule
`default_nettype wire
